/* File: common/jir_pkg.sv */
// Shared constants and types for the test port identification-select block.
package jir_pkg;

  localparam int IR_W = 4;
  localparam int DR_ID_W = 32;
  localparam int USER_W = 8;
  localparam int LEN_W = 6;

  localparam logic [IR_W-1:0] INSTR_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] INSTR_USER = 4'h2;
  localparam logic [IR_W-1:0] INSTR_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // Arbitrary identification value; bit 0 is forced to one on capture anyway.
  localparam logic [DR_ID_W-1:0] ID_DEFAULT = 32'h1234_5679;

  localparam int CLK_PERIOD_NS = 25;
  localparam int TCK_PERIOD_NS = 200;
  localparam int TCK_HALF = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // Mode sequences are sent least significant bit first.
  localparam logic [5:0] SEQ_RESET = 6'h1f;
  localparam logic [2:0] SEQ_RESET_N = 3'h6;
  localparam logic [5:0] SEQ_IR = 6'h03;
  localparam logic [2:0] SEQ_IR_N = 3'h4;
  localparam logic [5:0] SEQ_DR = 6'h01;
  localparam logic [2:0] SEQ_DR_N = 3'h3;
  localparam logic [5:0] SEQ_POST = 6'h01;
  localparam logic [2:0] SEQ_POST_N = 3'h2;

  typedef enum logic [3:0] {
    TAP_TLR, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } jir_tap_t;

  typedef enum logic [1:0] {
    CMD_RESET, CMD_IR, CMD_DR
  } jir_cmd_t;

  typedef enum logic [1:0] {
    HP_IDLE, HP_PRE, HP_SHIFT, HP_POST
  } jir_phase_t;

endpackage

/* File: common/jir_if.sv */
// Four-wire test port link between the host end and the device end.
`timescale 1ns/10ps
interface jir_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic tdo_line;

  // The serial output floats while not shifting; the board pulls it high.
  assign tdo_line = tdo_oe ? tdo : 1'b1;

  modport dev (
    input tck,
    input tms,
    input tdi,
    output tdo,
    output tdo_oe
  );

  modport host (
    output tck,
    output tms,
    output tdi,
    input tdo_line
  );
endinterface

/* File: verilog/jir_device.sv */
// Device end: test access port whose identification register masks serial input.
`timescale 1ns/10ps

module jir_device #(
  parameter logic [jir_pkg::DR_ID_W-1:0] ID_VALUE = jir_pkg::ID_DEFAULT,
  parameter int USER_W = jir_pkg::USER_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  jir_if.dev link,
  output logic [USER_W-1:0] user_q,
  output logic user_upd,
  output logic [jir_pkg::IR_W-1:0] instr_q,
  output logic id_sel,
  output jir_pkg::jir_tap_t tap_q
);

  typedef struct packed {
    logic tck_m;
    logic tck_s;
    logic tck_d;
    logic tms_m;
    logic tms_s;
    logic tdi_m;
    logic tdi_s;
    jir_pkg::jir_tap_t tap;
    logic [jir_pkg::IR_W-1:0] ir_sh;
    logic [jir_pkg::IR_W-1:0] ir;
    logic [jir_pkg::DR_ID_W-1:0] dr_sh;
    logic tdo;
    logic tdo_oe;
    logic [USER_W-1:0] user;
    logic user_upd;
    logic id_sel;
  } jir_dev_st_t;

  jir_dev_st_t st_reg;
  jir_dev_st_t st_next;

  function automatic jir_pkg::jir_tap_t tap_step(input jir_pkg::jir_tap_t s, input logic m);
    jir_pkg::jir_tap_t t;
    t = s;
    unique case (s)
      jir_pkg::TAP_TLR: begin
        t = m ? jir_pkg::TAP_TLR : jir_pkg::TAP_IDLE;
      end
      jir_pkg::TAP_IDLE: begin
        t = m ? jir_pkg::TAP_SEL_DR : jir_pkg::TAP_IDLE;
      end
      jir_pkg::TAP_SEL_DR: begin
        t = m ? jir_pkg::TAP_SEL_IR : jir_pkg::TAP_CAP_DR;
      end
      jir_pkg::TAP_CAP_DR: begin
        t = m ? jir_pkg::TAP_EX1_DR : jir_pkg::TAP_SH_DR;
      end
      jir_pkg::TAP_SH_DR: begin
        t = m ? jir_pkg::TAP_EX1_DR : jir_pkg::TAP_SH_DR;
      end
      jir_pkg::TAP_EX1_DR: begin
        t = m ? jir_pkg::TAP_UPD_DR : jir_pkg::TAP_PAU_DR;
      end
      jir_pkg::TAP_PAU_DR: begin
        t = m ? jir_pkg::TAP_EX2_DR : jir_pkg::TAP_PAU_DR;
      end
      jir_pkg::TAP_EX2_DR: begin
        t = m ? jir_pkg::TAP_UPD_DR : jir_pkg::TAP_SH_DR;
      end
      jir_pkg::TAP_UPD_DR: begin
        t = m ? jir_pkg::TAP_SEL_DR : jir_pkg::TAP_IDLE;
      end
      jir_pkg::TAP_SEL_IR: begin
        t = m ? jir_pkg::TAP_TLR : jir_pkg::TAP_CAP_IR;
      end
      jir_pkg::TAP_CAP_IR: begin
        t = m ? jir_pkg::TAP_EX1_IR : jir_pkg::TAP_SH_IR;
      end
      jir_pkg::TAP_SH_IR: begin
        t = m ? jir_pkg::TAP_EX1_IR : jir_pkg::TAP_SH_IR;
      end
      jir_pkg::TAP_EX1_IR: begin
        t = m ? jir_pkg::TAP_UPD_IR : jir_pkg::TAP_PAU_IR;
      end
      jir_pkg::TAP_PAU_IR: begin
        t = m ? jir_pkg::TAP_EX2_IR : jir_pkg::TAP_PAU_IR;
      end
      jir_pkg::TAP_EX2_IR: begin
        t = m ? jir_pkg::TAP_UPD_IR : jir_pkg::TAP_SH_IR;
      end
      jir_pkg::TAP_UPD_IR: begin
        t = m ? jir_pkg::TAP_SEL_DR : jir_pkg::TAP_IDLE;
      end
    endcase
    return t;
  endfunction

  logic tck_rise;
  logic tck_fall;
  logic sel_id;
  logic sel_user;
  logic shift_in;

  always_comb begin
    tck_rise = st_reg.tck_s & ~st_reg.tck_d;
    tck_fall = ~st_reg.tck_s & st_reg.tck_d;
    sel_id = (st_reg.ir == jir_pkg::INSTR_IDCODE);
    sel_user = (st_reg.ir == jir_pkg::INSTR_USER);
    // The identification path ignores the serial input and feeds a constant one.
    shift_in = sel_id ? 1'b1 : st_reg.tdi_s;

    st_next = st_reg;
    st_next.tck_m = link.tck;
    st_next.tck_s = st_reg.tck_m;
    st_next.tck_d = st_reg.tck_s;
    st_next.tms_m = link.tms;
    st_next.tms_s = st_reg.tms_m;
    st_next.tdi_m = link.tdi;
    st_next.tdi_s = st_reg.tdi_m;
    st_next.user_upd = 1'b0;

    if (tck_rise) begin
      unique case (st_reg.tap)
        jir_pkg::TAP_CAP_DR: begin
          if (sel_id) begin
            st_next.dr_sh = {ID_VALUE[jir_pkg::DR_ID_W-1:1], 1'b1};
          end else if (sel_user) begin
            st_next.dr_sh = jir_pkg::DR_ID_W'(st_reg.user);
          end else begin
            st_next.dr_sh = '0;
          end
        end
        jir_pkg::TAP_SH_DR: begin
          if (sel_id) begin
            // Ones shifted here reach downstream parts and their update stage.
            st_next.dr_sh = {shift_in, st_reg.dr_sh[jir_pkg::DR_ID_W-1:1]};
          end else if (sel_user) begin
            st_next.dr_sh[USER_W-1:0] = {shift_in, st_reg.dr_sh[USER_W-1:1]};
          end else begin
            st_next.dr_sh[0] = shift_in;
          end
        end
        jir_pkg::TAP_UPD_DR: begin
          if (sel_user) begin
            st_next.user = st_reg.dr_sh[USER_W-1:0];
            st_next.user_upd = 1'b1;
          end
        end
        jir_pkg::TAP_CAP_IR: begin
          st_next.ir_sh = jir_pkg::IR_CAPTURE;
        end
        jir_pkg::TAP_SH_IR: begin
          st_next.ir_sh = {st_reg.tdi_s, st_reg.ir_sh[jir_pkg::IR_W-1:1]};
        end
        jir_pkg::TAP_UPD_IR: begin
          // Any code other than identification or user data selects bypass.
          st_next.ir = st_reg.ir_sh;
        end
        default: begin
        end
      endcase
      st_next.tap = tap_step(st_reg.tap, st_reg.tms_s);
      if (st_next.tap == jir_pkg::TAP_TLR) begin
        st_next.ir = jir_pkg::INSTR_IDCODE;
      end
    end

    // The serial output changes on the falling edge so the far end samples a settled bit.
    if (tck_fall) begin
      if (st_reg.tap == jir_pkg::TAP_SH_DR) begin
        st_next.tdo = st_reg.dr_sh[0];
        st_next.tdo_oe = 1'b1;
      end else if (st_reg.tap == jir_pkg::TAP_SH_IR) begin
        st_next.tdo = st_reg.ir_sh[0];
        st_next.tdo_oe = 1'b1;
      end else begin
        st_next.tdo_oe = 1'b0;
      end
    end

    st_next.id_sel = (st_next.ir == jir_pkg::INSTR_IDCODE);

    if (!rst_n) begin
      st_next = '0;
      st_next.tap = jir_pkg::TAP_TLR;
      st_next.ir = jir_pkg::INSTR_IDCODE;
      st_next.id_sel = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end

  assign link.tdo = st_reg.tdo;
  assign link.tdo_oe = st_reg.tdo_oe;
  assign user_q = st_reg.user;
  assign user_upd = st_reg.user_upd;
  assign instr_q = st_reg.ir;
  assign id_sel = st_reg.id_sel;
  assign tap_q = st_reg.tap;

endmodule // jir_device

/* File: verilog/jir_host.sv */
// Host end: boundary-scan controller that makes the test clock and runs scans.
`timescale 1ns/10ps
module jir_host #(
  parameter int HALF = jir_pkg::TCK_HALF
) (
  input wire logic mclk,
  input wire logic rst_n,
  jir_if.host link,
  input wire logic cmd_valid,
  input wire jir_pkg::jir_cmd_t cmd_kind,
  input wire logic [jir_pkg::LEN_W-1:0] cmd_len,
  input wire logic [jir_pkg::DR_ID_W-1:0] cmd_wdata,
  input wire logic cmd_downstream,
  output logic busy,
  output logic done,
  output logic refused,
  output logic [jir_pkg::DR_ID_W-1:0] rdata,
  output logic id_selected
);

  typedef struct packed {
    logic [7:0] div;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo_m;
    logic tdo_s;
    jir_pkg::jir_phase_t ph;
    jir_pkg::jir_cmd_t kind;
    logic [5:0] seq;
    logic [jir_pkg::LEN_W-1:0] cnt;
    logic [jir_pkg::LEN_W-1:0] len;
    logic [jir_pkg::DR_ID_W-1:0] sh;
    logic [jir_pkg::DR_ID_W-1:0] rd;
    logic busy;
    logic done;
    logic refused;
    logic id_sel;
    logic [jir_pkg::IR_W-1:0] ir_new;
    logic samp;
  } jir_host_st_t;

  localparam logic [7:0] DIV_HALF = 8'(HALF);
  localparam logic [7:0] DIV_LAST = 8'(2 * HALF - 1);

  jir_host_st_t st_reg;
  jir_host_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tdo_m = link.tdo_line;
    st_next.tdo_s = st_reg.tdo_m;
    st_next.done = 1'b0;
    st_next.refused = 1'b0;

    if (!st_reg.busy) begin
      st_next.div = '0;
      st_next.tck = 1'b0;
      if (cmd_valid) begin
        // Downstream data cannot pass while identification is selected.
        if ((cmd_kind == jir_pkg::CMD_DR && (cmd_downstream && st_reg.id_sel || cmd_len == '0))
            || (cmd_kind == jir_pkg::CMD_IR && cmd_len == '0)) begin
          st_next.refused = 1'b1;
        end else begin
          st_next.busy = 1'b1;
          st_next.ph = jir_pkg::HP_PRE;
          st_next.kind = cmd_kind;
          st_next.len = cmd_len;
          st_next.sh = cmd_wdata;
          st_next.rd = '0;
          st_next.ir_new = cmd_wdata[jir_pkg::IR_W-1:0];
          unique case (cmd_kind)
            jir_pkg::CMD_RESET: begin
              st_next.seq = jir_pkg::SEQ_RESET;
              st_next.cnt = jir_pkg::LEN_W'(jir_pkg::SEQ_RESET_N);
            end
            jir_pkg::CMD_IR: begin
              st_next.seq = jir_pkg::SEQ_IR;
              st_next.cnt = jir_pkg::LEN_W'(jir_pkg::SEQ_IR_N);
            end
            default: begin
              st_next.seq = jir_pkg::SEQ_DR;
              st_next.cnt = jir_pkg::LEN_W'(jir_pkg::SEQ_DR_N);
            end
          endcase
        end
      end
    end else begin
      st_next.div = (st_reg.div == DIV_LAST) ? 8'h00 : st_reg.div + 8'h01;
      st_next.tck = (st_next.div >= DIV_HALF);
      // Mode and data change together with the falling edge of the test clock.
      if (st_next.div == 8'h00) begin
        if (st_reg.ph == jir_pkg::HP_SHIFT) begin
          st_next.tdi = st_reg.sh[0];
          st_next.tms = (st_reg.cnt == jir_pkg::LEN_W'(1));
        end else begin
          st_next.tms = st_reg.seq[0];
          st_next.tdi = 1'b0;
        end
      end
      // Sampling late in the high phase covers the device's synchroniser delay.
      if (st_reg.div == DIV_LAST) begin
        st_next.cnt = st_reg.cnt - jir_pkg::LEN_W'(1);
        st_next.seq = {1'b0, st_reg.seq[5:1]};
        // The wire runs one period behind the phase, so each answer bit is taken one period later.
        st_next.samp = (st_reg.ph == jir_pkg::HP_SHIFT);
        if (st_reg.samp) begin
          st_next.rd = {st_reg.tdo_s, st_reg.rd[jir_pkg::DR_ID_W-1:1]};
        end
        if (st_reg.ph == jir_pkg::HP_SHIFT) begin
          st_next.sh = {1'b0, st_reg.sh[jir_pkg::DR_ID_W-1:1]};
        end
        if (st_reg.cnt == jir_pkg::LEN_W'(1)) begin
          unique case (st_reg.ph)
            jir_pkg::HP_PRE: begin
              if (st_reg.kind == jir_pkg::CMD_RESET) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
                st_next.ph = jir_pkg::HP_IDLE;
                st_next.id_sel = 1'b1;
              end else begin
                st_next.ph = jir_pkg::HP_SHIFT;
                st_next.cnt = st_reg.len;
              end
            end
            jir_pkg::HP_SHIFT: begin
              st_next.ph = jir_pkg::HP_POST;
              st_next.seq = jir_pkg::SEQ_POST;
              // One extra period gives the last mode bit a rising edge of its own before the clock stops.
              st_next.cnt = jir_pkg::LEN_W'(jir_pkg::SEQ_POST_N) + jir_pkg::LEN_W'(1);
            end
            default: begin
              st_next.busy = 1'b0;
              st_next.done = 1'b1;
              st_next.ph = jir_pkg::HP_IDLE;
              st_next.rd = st_reg.rd >> (jir_pkg::DR_ID_W - int'(st_reg.len));
              if (st_reg.kind == jir_pkg::CMD_IR) begin
                st_next.id_sel = (st_reg.ir_new == jir_pkg::INSTR_IDCODE);
              end
            end
          endcase
        end
      end
    end

    if (!rst_n) begin
      st_next = '0;
      st_next.ph = jir_pkg::HP_IDLE;
      st_next.id_sel = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end

  assign link.tck = st_reg.tck;
  assign link.tms = st_reg.tms;
  assign link.tdi = st_reg.tdi;
  assign busy = st_reg.busy;
  assign done = st_reg.done;
  assign refused = st_reg.refused;
  assign rdata = st_reg.rd;
  assign id_selected = st_reg.id_sel;

endmodule // jir_host

/* File: testbench/jir_chk.sv */
// Checker that follows the test port state from the wire and watches the device answers.
`timescale 1ns/10ps
module jir_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic tdo_line
);
  // Next state for mode low and high, one nibble per state in the order of the state type.
  localparam logic [63:0] NX0 = 64'h1bddbba146644311;
  localparam logic [63:0] NX1 = 64'h2fefcc0287855920;
  logic tck_q;
  logic [3:0] st;
  logic [3:0] ir_sh;
  logic [3:0] ins;
  logic [5:0] nsh;
  logic last_tdi;
  wire rise = tck & ~tck_q;
  wire id = ins == jir_pkg::INSTR_IDCODE;
  wire byp = !id && ins != jir_pkg::INSTR_USER;
  wire sh_dr = rise && st == 4'h4;
  wire sh_ir = rise && st == 4'hb;

  // The tracker moves on the mclk edge that first sees tck high, so assertions see the old state.
  always_ff @(posedge mclk) begin
    tck_q <= rst_n & tck;
    if (!rst_n) begin
      st <= 4'h0;
      ins <= jir_pkg::INSTR_IDCODE;
      ir_sh <= 4'h0;
      nsh <= 6'h00;
      last_tdi <= 1'b0;
    end else if (rise) begin
      st <= tms ? NX1[st*4 +: 4] : NX0[st*4 +: 4];
      nsh <= (st == 4'h4 || st == 4'hb) ? nsh + 6'h01 : 6'h00;
      if (st == 4'h4) last_tdi <= tdi;
      if (st == 4'hb) ir_sh <= {tdi, ir_sh[3:1]};
      if (st == 4'h0) ins <= jir_pkg::INSTR_IDCODE;
      if (st == 4'hf) ins <= ir_sh;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_id_lsb_one: assert property (sh_dr && id && nsh == 6'h00 |-> tdo_line)
    else $error("identification scan did not start with a one");
  a_id_fill_ones: assert property (sh_dr && id && nsh >= 6'h20 |-> tdo_line)
    else $error("identification scan passed serial input through");
  a_bypass_zero: assert property (sh_dr && byp && nsh == 6'h00 |-> !tdo_line)
    else $error("bypass scan did not start with a zero");
  a_bypass_pass: assert property (sh_dr && byp && nsh != 6'h00 |-> tdo_line == last_tdi)
    else $error("bypass scan did not delay serial input by one bit");
  a_oe_in_shift: assert property (rise && (st == 4'h4 || st == 4'hb) |-> tdo_oe)
    else $error("serial output not driven while shifting");
  a_oe_idle_off: assert property (rise && st == 4'h1 |-> !tdo_oe)
    else $error("serial output driven while idle");
  a_ir_capture: assert property (sh_ir && nsh < 6'h04 |-> tdo == jir_pkg::IR_CAPTURE[nsh[1:0]])
    else $error("instruction scan did not return the capture pattern");

  cover property (sh_dr && id && nsh == 6'h27);
  cover property (sh_dr && byp && nsh == 6'h0f);
  cover property (rise && st == 4'hf && ir_sh == jir_pkg::INSTR_USER);
endmodule // jir_chk

/* File: testbench/jtag_id_register_select_tb.sv */
// Bench joining host and device ends and checking identification, bypass and update behaviour.
`timescale 1ns/10ps
module jtag_id_register_select_tb;
  // Arbitrary identification value for the device under test.
  localparam logic [31:0] IDV = 32'h0bad_cafe;
  localparam logic [31:0] IDX = IDV | 32'h1;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_downstream = 1'b0;
  jir_pkg::jir_cmd_t cmd_kind = jir_pkg::CMD_RESET;
  logic [5:0] cmd_len = 6'h00;
  logic [31:0] cmd_wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] w;
  logic busy, done, refused, id_selected, user_upd, id_sel, rf;
  logic [7:0] user_q;
  logic [7:0] uv = 8'h00;
  logic [3:0] instr_q;
  jir_pkg::jir_tap_t tap_q;
  logic [63:0] cap = 64'h0;
  integer seed = 32'hce9f0381;
  integer fails = 0;
  integer check_count = 0;
  integer n_upd = 0;
  integer i;

  // The device stands alone, so it is first in the chain, nearest the host output.
  jir_if lk ();
  always #12.5 mclk = ~mclk;

  jir_device #(.ID_VALUE(IDV)) jir_device_i (.mclk(mclk), .rst_n(rst_n), .link(lk), .user_q(user_q),
    .user_upd(user_upd), .instr_q(instr_q), .id_sel(id_sel), .tap_q(tap_q));
  jir_host jir_host_i (.mclk(mclk), .rst_n(rst_n), .link(lk), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .cmd_downstream(cmd_downstream), .busy(busy), .done(done),
    .refused(refused), .rdata(rdata), .id_selected(id_selected));
  jir_chk jir_chk_i (.mclk(mclk), .rst_n(rst_n), .tck(lk.tck), .tms(lk.tms), .tdi(lk.tdi), .tdo(lk.tdo),
    .tdo_oe(lk.tdo_oe), .tdo_line(lk.tdo_line));

  // The device state still shows the pre-edge state at the test clock rise, so each shift bit lands once.
  always @(posedge lk.tck) if (tap_q == jir_pkg::TAP_SH_DR) cap <= {lk.tdo_line, cap[63:1]};
  always @(posedge mclk) if (user_upd === 1'b1) n_upd <= n_upd + 1;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (e !== g) begin
      fails++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One idle period, the mode prelude, the data bits and two closing periods, each 2*HALF clocks.
  function automatic integer scan_cycles(input jir_pkg::jir_cmd_t k, input logic [5:0] l);
    integer pre;
    pre = (k == jir_pkg::CMD_IR) ? int'(jir_pkg::SEQ_IR_N) : int'(jir_pkg::SEQ_DR_N);
    if (k == jir_pkg::CMD_RESET) scan_cycles = int'(jir_pkg::SEQ_RESET_N) * 2 * jir_pkg::TCK_HALF;
    else scan_cycles = (1 + pre + int'(l) + 2) * 2 * jir_pkg::TCK_HALF;
  endfunction

  task automatic run(input jir_pkg::jir_cmd_t k, input logic [5:0] l, input logic [31:0] d, input logic ds);
    integer t;
    cmd_kind <= k;
    cmd_len <= l;
    cmd_wdata <= d;
    cmd_downstream <= ds;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    for (t = 0; t < 2000; t++) begin
      @(posedge mclk);
      if (done === 1'b1 || refused === 1'b1) break;
    end
    rf = refused;
    if (t == 2000) begin
      fails++;
      $display("wrong value scan_end: expected done, seen timeout");
      finish_test;
    end
    chk("scan_cycles", rf ? 32'h0 : scan_cycles(k, l), t);
    chk("busy_end", 32'h0, {31'h0, busy});
  endtask

  task automatic ir(input logic [3:0] c);
    run(jir_pkg::CMD_IR, 6'd4, {28'h0, c}, 1'b0);
    chk("instr", {28'h0, c}, {28'h0, instr_q});
    chk("ir_capture", {28'h0, jir_pkg::IR_CAPTURE}, rdata);
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("instr", {28'h0, jir_pkg::INSTR_IDCODE}, {28'h0, instr_q});
    chk("id_sel", 32'h1, {31'h0, id_sel});
    w = $random(seed);
    run(jir_pkg::CMD_DR, 6'd32, w, 1'b0);
    chk("id_read", IDX, rdata);
    chk("id_wire", IDX, cap[63:32]);
    run(jir_pkg::CMD_DR, 6'd8, w, 1'b1);
    chk("refused", 32'h1, {31'h0, rf});
    ir(jir_pkg::INSTR_USER);
    for (i = 0; i < 4; i++) begin
      w = $random(seed);
      run(jir_pkg::CMD_DR, 6'd8, w, 1'b0);
      chk("user_read", {24'h0, uv}, rdata);
      uv = w[7:0];
      chk("user_q", {24'h0, uv}, {24'h0, user_q});
    end
    chk("upd_count", 32'h4, n_upd);
    ir(jir_pkg::INSTR_BYPASS);
    chk("id_sel", 32'h0, {31'h0, id_sel});
    chk("host_id", 32'h0, {31'h0, id_selected});
    for (i = 0; i < 4; i++) begin
      w = $random(seed);
      run(jir_pkg::CMD_DR, 6'd16, w, 1'b1);
      chk("bypass", {16'h0, w[14:0], 1'b0}, rdata);
    end
    ir(jir_pkg::INSTR_IDCODE);
    run(jir_pkg::CMD_DR, 6'd8, 32'h5a, 1'b0);
    chk("user_hold", {24'h0, uv}, {24'h0, user_q});
    chk("upd_count", 32'h4, n_upd);
    chk("id_low", {24'h0, IDX[7:0]}, rdata);
    ir(jir_pkg::INSTR_BYPASS);
    run(jir_pkg::CMD_RESET, 6'd0, 32'h0, 1'b0);
    chk("instr", {28'h0, jir_pkg::INSTR_IDCODE}, {28'h0, instr_q});
    chk("host_id", 32'h1, {31'h0, id_selected});
    w = $random(seed);
    run(jir_pkg::CMD_DR, 6'd40, w, 1'b0);
    chk("fill_ones", 32'hff, {24'h0, cap[63:56]});
    chk("fill_id", IDX, cap[55:24]);
    finish_test;
  end
endmodule // jtag_id_register_select_tb
